// ---- hw/mca_defines.vh ----
/*
 * constants for the arithmetic/logical carry path: instruction fields,
 * alu and shifter codes, register offsets and reset values.
 * assumes it is included once by bare name from each design file.
 */
// What this block does
// - first operand is dest accumulator, two-operand functions
// - second operand is source accumulator, all functions
// - function comes from instruction bits five to seven
// - msb carry-out inverts the preselected carry
// - carry plus result form seventeen-bit shifter word
// - store carry and result unless store suppressed
// - skip test runs even when store suppressed
// - subtract by inverted subtrahend plus carry-in one
// - code 000 inverts source, carry unchanged
// - code 001 negates, carry inverts when source zero
// - code 010 passes source, carry unchanged
// - code 011 increments, carry inverts on wrap
// - code 100 adds inverted source, carry if src<dst
// - code 101 subtracts, carry if src<=dst
// - code 110 adds, carry if sum overflows
// - code 111 ands, carry unchanged
// - shift field passes, rotates left, right, swaps
// - carry base field: flag, zero, one, inverted
// - skip field selects eight shifted-output tests
`ifndef MCA_DEFINES_VH
`define MCA_DEFINES_VH

// instruction fields, instruction bit 0 (the msb) is verilog bit 15
`define MCA_F_CLASS 15
`define MCA_F_SRC_HI 14
`define MCA_F_SRC_LO 13
`define MCA_F_DST_HI 12
`define MCA_F_DST_LO 11
`define MCA_F_OP_HI 10
`define MCA_F_OP_LO 8
`define MCA_F_ROT_HI 7
`define MCA_F_ROT_LO 6
`define MCA_F_BASE_HI 5
`define MCA_F_BASE_LO 4
`define MCA_F_NOSTORE 3
`define MCA_F_TEST_HI 2
`define MCA_F_TEST_LO 0

// alu function codes
`define MCA_OP_INV 3'h0
`define MCA_OP_TWOS 3'h1
`define MCA_OP_PASS 3'h2
`define MCA_OP_INC 3'h3
`define MCA_OP_ADDINV 3'h4
`define MCA_OP_DIFF 3'h5
`define MCA_OP_SUM 3'h6
`define MCA_OP_AND 3'h7

// shifter codes
`define MCA_ROT_NONE 2'h0
`define MCA_ROT_LEFT 2'h1
`define MCA_ROT_RIGHT 2'h2
`define MCA_ROT_SWAP 2'h3

// carry base codes
`define MCA_BASE_FLAG 2'h0
`define MCA_BASE_ZERO 2'h1
`define MCA_BASE_ONE 2'h2
`define MCA_BASE_INV 2'h3

// register word addresses on the bus
`define MCA_REG_AC0 4'h0
`define MCA_REG_AC1 4'h1
`define MCA_REG_AC2 4'h2
`define MCA_REG_AC3 4'h3
`define MCA_REG_CARRY 4'h4
`define MCA_REG_INSTR 4'h5
`define MCA_REG_STATUS 4'h6

// reset values
`define MCA_RST_WORD 16'h0000
`define MCA_RST_BUS 32'h0000_0000

`endif

// ---- hw/mca_alu.v ----
/*
 * sixteen-bit alu of the carry path: eight functions, carry-out of the
 * most significant bit and the preselected-carry inversion.
 * assumes purely combinational use inside the carry path top.
 */
`include "mca_defines.vh"

module mca_alu (
   input wire [2:0] op_in,        // function code
   input wire [15:0] dst_in,      // destination accumulator value
   input wire [15:0] src_in,      // source accumulator value
   input wire presel_in,          // preselected carry
   output reg [15:0] res_out,     // alu result
   output reg carry_out           // alu carry result
);

   reg [15:0] opa;      // adder first input
   reg [15:0] opb;      // adder second input
   reg cin;             // adder carry-in
   reg arith;           // function produces a carry-out
   reg [16:0] sum;      // seventeen-bit adder output

   // operand steering, adder and result select
   always @* begin
      opa = 16'h0000;
      opb = 16'h0000;
      cin = 1'b0;
      arith = 1'b1;
      case (op_in)
         `MCA_OP_TWOS: begin     // two's complement, carry on zero
            opb = ~src_in;
            cin = 1'b1;
         end
         `MCA_OP_INC: begin      // source plus one, wraps
            opb = src_in;
            cin = 1'b1;
         end
         `MCA_OP_ADDINV: begin   // dst plus inverted src
            opa = dst_in;
            opb = ~src_in;
         end
         `MCA_OP_DIFF: begin     // inverted subtrahend, carry-in one
            opa = dst_in;
            opb = ~src_in;
            cin = 1'b1;
         end
         `MCA_OP_SUM: begin      // plain add
            opa = dst_in;
            opb = src_in;
         end
         default: begin          // logical functions leave carry alone
            arith = 1'b0;
         end
      endcase
      sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
      case (op_in)
         `MCA_OP_INV: res_out = ~src_in;
         `MCA_OP_PASS: res_out = src_in;
         `MCA_OP_AND: res_out = dst_in & src_in;
         default: res_out = sum[15:0];
      endcase
      // msb carry-out inverts the preselected carry
      carry_out = presel_in ^ (arith & sum[16]);
   end

endmodule // mca_alu

// ---- hw/mca_carry_path.v ----
/*
 * arithmetic/logical carry path: four accumulators, the carry flag, the
 * alu, the seventeen-bit shifter, the store and the skip test, all
 * reached over an avalon-mm slave with waitrequest.
 * assumes a master on the same clock that holds each request until it
 * samples waitrequest low; no input needs synchronising.
 */
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`include "mca_defines.vh"

module mca_carry_path (
   input wire REF_CLK_IN,              // 20 mhz processor clock
   input wire SYS_RST_IN,              // async reset, active high
   input wire [3:0] AVS_ADDRESS_IN,    // word address
   input wire AVS_READ_IN,             // read request
   input wire AVS_WRITE_IN,            // write request
   input wire [31:0] AVS_WRITEDATA_IN, // write data
   input wire [3:0] AVS_BYTEENABLE_IN, // byte enables
   output reg [31:0] AVS_READDATA_OUT, // read data
   output reg AVS_WAITREQUEST_OUT,     // stall, low one cycle to answer
   output reg CARRY_FLAG_OUT,          // current carry flag
   output reg SKIP_OUT                 // skip decision of last instruction
);

   // bus states
   localparam ST_IDLE = 2'h0;   // waiting for a request
   localparam ST_EXEC = 2'h1;   // committing an instruction
   localparam ST_ACK = 2'h2;    // answering, waitrequest low

   reg [1:0] state_r;           // bus state
   reg [1:0] state_nxt;         // next bus state
   reg [15:0] acc_r [0:3];      // accumulator file
   reg carry_r;                 // carry flag
   reg [15:0] instr_r;          // last instruction word
   reg [15:0] result_r;         // last shifted result
   reg shcarry_r;               // last shifted carry
   reg skip_r;                  // last skip decision
   reg stored_r;                // last instruction stored its result
   reg [31:0] rdata_nxt;        // read data for the answer
   integer i;                   // reset loop index

   // instruction fields
   wire [1:0] src_sel;          // source accumulator index
   wire [1:0] dst_sel;          // destination accumulator index
   wire [2:0] op_code;          // alu function
   wire [1:0] rot_code;         // rotate_swap_select
   wire [1:0] base_code;        // carry_base_select
   wire store_suppress;         // no-load bit
   wire [2:0] test_code;        // branch_over_test

   // datapath nets
   wire [15:0] src_val;         // source accumulator value
   wire [15:0] dst_val;         // destination accumulator value
   reg preselected_carry;       // carry base for the alu
   wire [15:0] alu_res;         // alu result
   wire alu_carry_result;       // carry after msb inversion
   reg [15:0] shifted_res;      // shifter result
   reg shifted_carry;           // shifter carry
   reg skip_now;                // skip test on shifter output
   wire res_zero;               // shifted result is zero

   // merged lower half-word write, honouring byte enables
   reg [15:0] wr_half;          // write data merged into target

   // field extraction, bit 0 of the word is the msb
   assign src_sel = instr_r[`MCA_F_SRC_HI:`MCA_F_SRC_LO];
   assign dst_sel = instr_r[`MCA_F_DST_HI:`MCA_F_DST_LO];
   assign op_code = instr_r[`MCA_F_OP_HI:`MCA_F_OP_LO];
   assign rot_code = instr_r[`MCA_F_ROT_HI:`MCA_F_ROT_LO];
   assign base_code = instr_r[`MCA_F_BASE_HI:`MCA_F_BASE_LO];
   assign store_suppress = instr_r[`MCA_F_NOSTORE];
   assign test_code = instr_r[`MCA_F_TEST_HI:`MCA_F_TEST_LO];

   // operand fetch from the accumulator file
   assign src_val = acc_r[src_sel];
   assign dst_val = acc_r[dst_sel];

   // carry base select
   always @* begin
      case (base_code)
         `MCA_BASE_FLAG: preselected_carry = carry_r;
         `MCA_BASE_ZERO: preselected_carry = 1'b0;
         `MCA_BASE_ONE: preselected_carry = 1'b1;
         default: preselected_carry = ~carry_r;
      endcase
   end

   // eight-function alu with the carry inversion
   mca_alu u_alu (
      .op_in(op_code),
      .dst_in(dst_val),
      .src_in(src_val),
      .presel_in(preselected_carry),
      .res_out(alu_res),
      .carry_out(alu_carry_result)
   );

   // shifter on the seventeen-bit carry-plus-result word
   always @* begin
      case (rot_code)
         `MCA_ROT_LEFT: begin   // rotate left through carry
            shifted_carry = alu_res[15];
            shifted_res = {alu_res[14:0], alu_carry_result};
         end
         `MCA_ROT_RIGHT: begin  // rotate right through carry
            shifted_carry = alu_res[0];
            shifted_res = {alu_carry_result, alu_res[15:1]};
         end
         `MCA_ROT_SWAP: begin   // swap bytes, carry kept
            shifted_carry = alu_carry_result;
            shifted_res = {alu_res[7:0], alu_res[15:8]};
         end
         default: begin         // pass unchanged
            shifted_carry = alu_carry_result;
            shifted_res = alu_res;
         end
      endcase
   end

   assign res_zero = (shifted_res == 16'h0000);

   // skip test, independent of the store suppress bit
   always @* begin
      case (test_code)
         3'h0: skip_now = 1'b0;                        // never
         3'h1: skip_now = 1'b1;                        // always
         3'h2: skip_now = ~shifted_carry;              // carry zero
         3'h3: skip_now = shifted_carry;               // carry set
         3'h4: skip_now = res_zero;                    // result zero
         3'h5: skip_now = ~res_zero;                   // result set
         3'h6: skip_now = ~shifted_carry | res_zero;   // either zero
         default: skip_now = shifted_carry & ~res_zero; // both set
      endcase
   end

   // byte-enable merge into the current value of the target
   always @* begin
      case (AVS_ADDRESS_IN)
         `MCA_REG_AC0: wr_half = acc_r[0];
         `MCA_REG_AC1: wr_half = acc_r[1];
         `MCA_REG_AC2: wr_half = acc_r[2];
         `MCA_REG_AC3: wr_half = acc_r[3];
         `MCA_REG_INSTR: wr_half = instr_r;
         default: wr_half = {15'h0000, carry_r};
      endcase
      if (AVS_BYTEENABLE_IN[0]) begin
         wr_half[7:0] = AVS_WRITEDATA_IN[7:0];
      end
      if (AVS_BYTEENABLE_IN[1]) begin
         wr_half[15:8] = AVS_WRITEDATA_IN[15:8];
      end
   end

   // read data decode, unmapped addresses read zero
   always @* begin
      if (AVS_ADDRESS_IN == `MCA_REG_AC0) begin
         rdata_nxt = {16'h0000, acc_r[0]};
      end else if (AVS_ADDRESS_IN == `MCA_REG_AC1) begin
         rdata_nxt = {16'h0000, acc_r[1]};
      end else if (AVS_ADDRESS_IN == `MCA_REG_AC2) begin
         rdata_nxt = {16'h0000, acc_r[2]};
      end else if (AVS_ADDRESS_IN == `MCA_REG_AC3) begin
         rdata_nxt = {16'h0000, acc_r[3]};
      end else if (AVS_ADDRESS_IN == `MCA_REG_CARRY) begin
         rdata_nxt = {31'h0000_0000, carry_r};
      end else if (AVS_ADDRESS_IN == `MCA_REG_INSTR) begin
         rdata_nxt = {16'h0000, instr_r};
      end else if (AVS_ADDRESS_IN == `MCA_REG_STATUS) begin
         // shifted result, stored, shifted carry, skip
         rdata_nxt = {result_r, 13'h0000, stored_r, shcarry_r, skip_r};
      end else begin
         rdata_nxt = `MCA_RST_BUS;
      end
   end

   // bus state sequencing
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (AVS_WRITE_IN && AVS_ADDRESS_IN == `MCA_REG_INSTR) begin
               state_nxt = ST_EXEC;   // new instruction, commit next
            end else if (AVS_READ_IN || AVS_WRITE_IN) begin
               state_nxt = ST_ACK;    // plain access answers next
            end
         end
         ST_EXEC: begin
            state_nxt = ST_ACK;
         end
         ST_ACK: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // state, bus outputs and read capture
   always @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_r <= ST_IDLE;
         AVS_WAITREQUEST_OUT <= 1'b1;
         AVS_READDATA_OUT <= `MCA_RST_BUS;
      end else begin
         state_r <= state_nxt;
         // waitrequest low exactly while in the answer state
         AVS_WAITREQUEST_OUT <= (state_nxt != ST_ACK);
         if (state_r == ST_IDLE && AVS_READ_IN) begin
            AVS_READDATA_OUT <= rdata_nxt; // capture read value
         end else if (state_nxt == ST_IDLE) begin
            AVS_READDATA_OUT <= `MCA_RST_BUS;
         end
      end
   end

   // accumulator file, carry flag and instruction state
   always @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         for (i = 0; i < 4; i = i + 1) begin
            acc_r[i] <= `MCA_RST_WORD;
         end
         carry_r <= 1'b0;
         instr_r <= `MCA_RST_WORD;
         result_r <= `MCA_RST_WORD;
         shcarry_r <= 1'b0;
         skip_r <= 1'b0;
         stored_r <= 1'b0;
         CARRY_FLAG_OUT <= 1'b0;
         SKIP_OUT <= 1'b0;
      end else if (state_r == ST_IDLE && AVS_WRITE_IN) begin
         // software write to a register
         if (AVS_ADDRESS_IN == `MCA_REG_AC0) begin
            acc_r[0] <= wr_half;
         end else if (AVS_ADDRESS_IN == `MCA_REG_AC1) begin
            acc_r[1] <= wr_half;
         end else if (AVS_ADDRESS_IN == `MCA_REG_AC2) begin
            acc_r[2] <= wr_half;
         end else if (AVS_ADDRESS_IN == `MCA_REG_AC3) begin
            acc_r[3] <= wr_half;
         end else if (AVS_ADDRESS_IN == `MCA_REG_CARRY) begin
            carry_r <= wr_half[0];
            CARRY_FLAG_OUT <= wr_half[0];
         end else if (AVS_ADDRESS_IN == `MCA_REG_INSTR) begin
            instr_r <= wr_half;
         end
      end else if (state_r == ST_EXEC && instr_r[`MCA_F_CLASS]) begin
         // shifter output is always recorded and tested
         result_r <= shifted_res;
         shcarry_r <= shifted_carry;
         skip_r <= skip_now;
         SKIP_OUT <= skip_now;
         stored_r <= ~store_suppress;
         if (!store_suppress) begin
            // carry and destination load together
            acc_r[dst_sel] <= shifted_res;
            carry_r <= shifted_carry;
            CARRY_FLAG_OUT <= shifted_carry;
         end
      end
   end

endmodule // mca_carry_path

// ---- tb/mca_host_model.sv ----
/*
 * decoder side model: avalon-mm master that moves words to the carry path.
 * assumes the slave answers by pulling waitrequest low for one cycle.
 */
module mca_host_model (
   input wire logic clk_in,          // processor clock
   input wire logic wait_in,         // slave stall
   input wire logic [31:0] rdata_in, // read data
   output logic [3:0] addr_out,      // word address
   output logic rd_out,              // read request
   output logic wr_out,              // write request
   output logic [31:0] wdata_out,    // write data
   output logic [3:0] be_out         // byte enables
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus at time zero
   initial begin
      addr_out = 4'h0;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 32'h0000_0000;
      be_out = 4'h0;
   end

   // write one word, hold until the answering edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= {16'h0000, d};
      be_out <= be;
      wr_out <= 1'b1;
      do @(posedge clk_in); while (wait_in !== 1'b0);
      wr_out <= 1'b0;
      wdata_out <= ~wdata_out; // released data no longer valid
   endtask

   // read one word, data taken at the answering edge
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      do @(posedge clk_in); while (wait_in !== 1'b0);
      d = rdata_in;
      rd_out <= 1'b0;
   endtask
endmodule // mca_host_model

// ---- tb/mca_carry_path_properties.sv ----
/*
 * port checker for the carry path: bus turnaround and instruction effects.
 * assumes the master adds an idle cycle between requests.
 */
module mca_carry_path_properties (
   input wire REF_CLK_IN,              // clock
   input wire SYS_RST_IN,              // reset
   input wire [3:0] AVS_ADDRESS_IN,    // address
   input wire AVS_READ_IN,             // read
   input wire AVS_WRITE_IN,            // write
   input wire [31:0] AVS_WRITEDATA_IN, // write data
   input wire [3:0] AVS_BYTEENABLE_IN, // byte enables
   input wire [31:0] AVS_READDATA_OUT, // read data
   input wire AVS_WAITREQUEST_OUT,     // stall
   input wire CARRY_FLAG_OUT,          // carry flag
   input wire SKIP_OUT                 // skip decision
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // an executable instruction word on the bus
   wire ins = AVS_ADDRESS_IN == 4'h5 && AVS_WRITEDATA_IN[15] && AVS_BYTEENABLE_IN[1:0] == 2'h3;
   wire [7:0] low = AVS_WRITEDATA_IN[7:0];

   wait_pulse_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
      else $error("waitrequest low longer than one cycle");
   rdata_idle_a: assert property (AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT == 32'h0000_0000)
      else $error("read data outside answer");
   read_turn_a: assert property ($rose(AVS_READ_IN) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
      else $error("read answer late or early");
   instr_turn_a: assert property ($rose(AVS_WRITE_IN) && ins |-> AVS_WAITREQUEST_OUT[*2] ##1 !AVS_WAITREQUEST_OUT)
      else $error("instruction answer late or early");
   noload_keep_a: assert property ($rose(AVS_WRITE_IN) && ins && low[3] |=> $stable(CARRY_FLAG_OUT)[*3])
      else $error("carry stored under no-load");
   carry_commit_a: assert property ($changed(CARRY_FLAG_OUT) |-> !AVS_WAITREQUEST_OUT)
      else $error("carry changed outside an answer");
   skip_commit_a: assert property ($changed(SKIP_OUT) |-> !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h5)
      else $error("skip changed outside an instruction");
   always_skip_a: assert property ($rose(AVS_WRITE_IN) && ins && low[2:0] == 3'h1 |-> ##3 SKIP_OUT)
      else $error("unconditional skip missing");
   never_skip_a: assert property ($rose(AVS_WRITE_IN) && ins && low[2:0] == 3'h0 |-> ##3 !SKIP_OUT)
      else $error("skip without test");
   base_one_a: assert property ($rose(AVS_WRITE_IN) && ins && AVS_WRITEDATA_IN[10:3] == 8'h44 |-> ##3 CARRY_FLAG_OUT)
      else $error("carry base one lost");
   base_zero_a: assert property ($rose(AVS_WRITE_IN) && ins && AVS_WRITEDATA_IN[10:3] == 8'h42 |-> ##3 !CARRY_FLAG_OUT)
      else $error("carry base zero lost");
endmodule // mca_carry_path_properties

bind mca_carry_path mca_carry_path_properties mca_carry_path_properties_inst (.*);

// ---- tb/mca_carry_path_tb_top.sv ----
/*
 * testbench: drives instructions through the bus and checks every result.
 * assumes the host model speaks avalon-mm to the carry path.
 */
module mca_carry_path_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire [3:0] adr, ben;
   wire rdq, wrq, wq, cf, skp;
   wire [31:0] wd, rdat;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [15:0] sv[4] = '{16'h0000, 16'hffff, 16'h8000, 16'h1234};
   logic [15:0] dv[4] = '{16'h0000, 16'h0001, 16'h8000, 16'hffff};

   always #25 clk = ~clk;

   mca_carry_path mca_carry_path_inst (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr),
      .AVS_READ_IN(rdq), .AVS_WRITE_IN(wrq), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(ben),
      .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wq), .CARRY_FLAG_OUT(cf), .SKIP_OUT(skp));
   mca_host_model mca_host_model_inst (.clk_in(clk), .wait_in(wq), .rdata_in(rdat), .addr_out(adr),
      .rd_out(rdq), .wr_out(wrq), .wdata_out(wd), .be_out(ben));

   // compare one value and count it
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // reference: alu, carry, shifter and skip test
   function automatic void calc(input logic [2:0] op, input logic [1:0] rot, base, input logic [15:0] s, d,
      input logic c, input logic [2:0] k, output logic [15:0] r, output logic nc, tst);
      logic [16:0] t;
      logic p;
      p = base == 2'h0 ? c : base == 2'h1 ? 1'b0 : base == 2'h2 ? 1'b1 : ~c;
      case (op)
         3'h0: t = {1'b0, ~s};
         3'h1: t = {1'b0, ~s} + 17'h0_0001;
         3'h2: t = {1'b0, s};
         3'h3: t = {1'b0, s} + 17'h0_0001;
         3'h4: t = {1'b0, d} + {1'b0, ~s};
         3'h5: t = {1'b0, d} + {1'b0, ~s} + 17'h0_0001;
         3'h6: t = {1'b0, d} + {1'b0, s};
         default: t = {1'b0, d & s};
      endcase
      p = p ^ t[16];
      case (rot)
         2'h0: {nc, r} = {p, t[15:0]};
         2'h1: {nc, r} = {t[15:0], p};
         2'h2: {nc, r} = {t[0], p, t[15:1]};
         default: {nc, r} = {p, t[7:0], t[15:8]};
      endcase
      tst = skt(k, nc, r == 16'h0000);
   endfunction

   // skip test on the shifted output
   function automatic logic skt(input logic [2:0] k, input logic nc, z);
      logic [7:0] m;
      m = {nc & !z, !nc | z, !z, z, nc, !nc, 1'b1, 1'b0};
      return m[k];
   endfunction

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc > 60000) begin
         errors++;
         complete_run();
      end
   end

   initial begin
      logic [31:0] v, st;
      logic [15:0] r, ins;
      logic nc, tk, c, ns;
      logic [1:0] a, b;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 16; k++) begin
         if (k != 5) begin
            mca_host_model_inst.rd(k[3:0], v);
            chk("reset word", v, 32'h0000_0000);
         end
      end
      for (int op = 0; op < 8; op++) for (int rt = 0; rt < 4; rt++) for (int bs = 0; bs < 4; bs++)
      for (int i = 0; i < 4; i++) begin
         a = i[1:0];
         b = ~a;
         c = bs[0] ^ i[0];
         ns = i[0] ^ op[0];
         ins = {1'b1, a, b, op[2:0], rt[1:0], bs[1:0], ns, 3'(op + rt + bs + i)};
         mca_host_model_inst.wr({2'h0, a}, sv[i], 4'hf);
         mca_host_model_inst.wr({2'h0, b}, dv[i], 4'hf);
         mca_host_model_inst.wr(4'h4, {15'h0000, c}, 4'hf);
         mca_host_model_inst.wr(4'h5, ins, 4'hf);
         calc(op[2:0], rt[1:0], bs[1:0], sv[i], dv[i], c, ins[2:0], r, nc, tk);
         mca_host_model_inst.rd({2'h0, b}, v);
         chk("dest acc", v, {16'h0000, ns ? dv[i] : r});
         mca_host_model_inst.rd(4'h4, v);
         chk("carry", v, {31'h0000_0000, ns ? c : nc});
         chk("carry pin", {31'h0000_0000, cf}, {31'h0000_0000, ns ? c : nc});
         mca_host_model_inst.rd(4'h6, st);
         chk("status", st, {r, 13'h0000, !ns, nc, tk});
         chk("skip pin", {31'h0000_0000, skp}, {31'h0000_0000, tk});
      end
      mca_host_model_inst.wr(4'h6, 16'hffff, 4'hf);
      mca_host_model_inst.rd(4'h6, v);
      chk("status kept", v, st);
      mca_host_model_inst.wr(4'h9, 16'h5a5a, 4'hf);
      mca_host_model_inst.rd(4'h9, v);
      chk("unmapped", v, 32'h0000_0000);
      mca_host_model_inst.wr(4'h0, 16'h1234, 4'hf);
      mca_host_model_inst.wr(4'h0, 16'h5555, 4'h0);
      mca_host_model_inst.wr(4'h0, 16'hffcd, 4'h1);
      mca_host_model_inst.wr(4'h5, 16'h0900, 4'hf);
      mca_host_model_inst.rd(4'h1, v);
      mca_host_model_inst.rd(4'h0, st);
      chk("byte lanes", st, 32'h0000_12cd);
      mca_host_model_inst.wr(4'h5, 16'h0b00, 4'hf);
      mca_host_model_inst.rd(4'h1, st);
      chk("class bit", st, v);
      // mid-run reset clears accumulators, carry, status and both pins
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         mca_host_model_inst.rd(k[3:0], v);
         chk("reset again", v, 32'h0000_0000);
      end
      chk("reset pins", {30'h0000_0000, cf, skp}, 32'h0000_0000);
      complete_run();
   end
endmodule // mca_carry_path_tb_top
